//--- design/fsr_status_regs.sv
`timescale 1ns/10ps
// Behaviour
// - Opcodes 09h/35h return register two, anytime
// - Register two repeats while select stays low
// - Register two fixed bit positions 7 to 1
// - Register two bit zero mirrors busy flag
// - Erase suspend sets flag, resume clears it
// - Program suspend sets flag, resume clears it
// - Lock bits set once, block sector writes
// - Complement bit defaults zero, feeds protection
// - Quad takeover disables protect and hold pins
// - Quad read and quad entry always accepted
// - Volatile bits clear on i_reset, not on the pin reset
// - Opcodes 95h/15h return register three, repeating
// - Drive field selects 67/100/83/50 percent
// - Wrap field selects 8/16/32/64 bytes
// - Pin select chooses hold or reset input
// - Blank flag clears on programming, set again by reset
// - Power-on mode bit is cleared by reset, so addressing always starts 3-byte
// - Bit zero shows current address mode
// - Opcode 31h plus one byte writes register
module fsr_status_regs
	import fsr_pkg::*;
(
	input  wire logic       i_clk,              // System clock, 125 MHz
	input  wire logic       i_reset,            // Asynchronous reset, active high
	input  wire logic       i_spi_sclk,         // Serial clock pin from host
	input  wire logic       i_spi_cs_n,         // Chip select pin, active low
	input  wire logic       i_spi_mosi,         // Serial data in pin
	input  wire logic       i_wp_n,             // Write protect pin, active low
	input  wire logic       i_hold_reset_n,     // Shared hold/reset pin, active low
	input  wire logic       i_write_busy,       // Program/erase/write cycle running
	input  wire logic       i_erase_suspend,    // Pulse: erase suspended
	input  wire logic       i_erase_resume,     // Pulse: erase resumed
	input  wire logic       i_program_suspend,  // Pulse: program suspended
	input  wire logic       i_program_resume,   // Pulse: program resumed
	input  wire logic       i_byte_programmed,  // Pulse: a byte of the array programmed
	input  wire logic       i_enter_current_address_mode_flag,      // Pulse: switch to 4-byte addressing
	input  wire logic       i_exit_current_address_mode_flag,       // Pulse: switch to 3-byte addressing
	output logic            o_spi_miso,         // Serial data out pin
	output logic            o_spi_miso_oe,      // Data out enable, high while driving
	output logic [7:0]      o_second_status,    // Register two as read
	output logic [7:0]      o_third_status,     // Register three as read
	output logic [2:0]      o_security_lock,    // Locks a, b, c: sector writes blocked
	output logic            o_protection_complement, // Complement for array protection
	output logic            o_write_protect_active,  // Protect pin asserted and honoured
	output logic            o_hold_active,      // Hold asserted and honoured
	output logic            o_pin_reset_active, // Pin reset asserted and honoured
	output logic [6:0]      o_drive_percent,    // Output drive in percent
	output logic [6:0]      o_wrap_bytes,       // Wrap burst length in bytes
	output logic            o_address_current_address_mode_flag,    // Current address mode is 4-byte
	output logic            o_quad_read_start,  // Pulse: quad I/O fast read opcode taken
	output logic            o_quad_mode_entry   // Pulse: quad peripheral entry opcode taken
);

	// Opcode classes, used by the state machine and the write path
	function automatic logic is_read2(input logic [7:0] op);
		return (op == OP_READ2_A) || (op == OP_READ2_B);
	endfunction

	function automatic logic is_read3(input logic [7:0] op);
		return (op == OP_READ3_A) || (op == OP_READ3_B);
	endfunction

	function automatic logic is_write3(input logic [7:0] op);
		return (op == OP_WRITE3_A) || (op == OP_WRITE3_B);
	endfunction

	function automatic logic [6:0] drive_pct(input logic [1:0] code);
		case (code)
			2'h0:    return DRIVE_PCT_00;
			2'h1:    return DRIVE_PCT_01;
			2'h2:    return DRIVE_PCT_10;
			default: return DRIVE_PCT_11;
		endcase
	endfunction

	logic [4:0] pins_s;
	logic       sclk_s;
	logic       cs_n_s;
	logic       mosi_s;
	logic       wp_n_s;
	logic       hold_n_s;
	logic       sclk_prev_q;
	logic       cs_prev_q;
	fsr_state_t state_q;
	fsr_state_t state_d;
	logic [2:0] bit_cnt_q;
	logic [7:0] in_sr_q;
	logic [7:0] op_q;
	logic       sel3_q;
	logic [2:0] out_cnt_q;
	logic [7:0] out_sr_q;
	logic [7:0] out_sr_d;
	logic       miso_d;
	logic       wel_q;
	logic       wel_d;
	logic       mode_init_q;
	fsr_sr2_t   sr2_q;
	fsr_sr2_t   sr2_d;
	fsr_sr3_t   sr3_q;
	fsr_sr3_t   sr3_d;

	// Pins are foreign to i_clk; the serial clock is only sampled, never used as a clock
	fsr_sync #(
		.W    (5),
		.INIT (PIN_IDLE)
	) u_sync (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_async ({i_spi_sclk, i_spi_cs_n, i_spi_mosi, i_wp_n, i_hold_reset_n}),
		.o_sync  (pins_s)
	);

	assign sclk_s   = pins_s[4];
	assign cs_n_s   = pins_s[3];
	assign mosi_s   = pins_s[2];
	assign wp_n_s   = pins_s[1];
	assign hold_n_s = pins_s[0];

	// Edge finding on the synchronised link clock and select
	wire       sclk_rise = sclk_s & ~sclk_prev_q;
	wire       sclk_fall = ~sclk_s & sclk_prev_q;
	wire       cs_rise   = cs_n_s & ~cs_prev_q;
	wire       byte_end  = sclk_rise && (bit_cnt_q == 3'h7);
	wire [7:0] in_next   = {in_sr_q[6:0], mosi_s};
	wire       op_end    = byte_end && (state_q == S_OPCODE);

	// A write lands only after exactly one data byte, latch set, no cycle running
	wire       wr_commit = cs_rise && (state_q == S_WDONE) && wel_q && !i_write_busy;
	wire       wr_sr2    = wr_commit && (op_q == OP_WRITE2);
	wire       wr_sr3    = wr_commit && is_write3(op_q);
	wire       op_only   = cs_rise && (state_q == S_OPDONE);

	// Bytes as the host sees them; bit zero of register two is the live busy flag
	wire [7:0] sr2_view  = {sr2_q[7:1], i_write_busy};
	wire [7:0] sr3_view  = sr3_q;
	wire [7:0] read_byte = sel3_q ? sr3_view : sr2_view;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			sclk_prev_q <= 1'b0;
			cs_prev_q   <= 1'b1;
		end else begin
			sclk_prev_q <= sclk_s;
			cs_prev_q   <= cs_n_s;
		end
	end

	// Frame sequencing; a raised select always ends the frame
	always_comb begin
		state_d = state_q;
		if (cs_n_s) begin
			state_d = S_IDLE;
		end else begin
			case (state_q)
				S_IDLE: begin
					state_d = S_OPCODE;
				end
				S_OPCODE: begin
					if (byte_end) begin
						if (is_read2(in_next) || is_read3(in_next)) begin
							state_d = S_READ;
						end else if ((in_next == OP_WRITE2) || is_write3(in_next)) begin
							state_d = S_WDATA;
						end else begin
							state_d = S_OPDONE;
						end
					end
				end
				S_WDATA: begin
					if (byte_end) begin
						state_d = S_WDONE;
					end
				end
				S_WDONE, S_OPDONE: begin
					// Extra bits void the command
					if (sclk_rise) begin
						state_d = S_IGNORE;
					end
				end
				default: begin
					state_d = state_q;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state_q <= S_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Serial input: MSB first, sampled on the rising link edge
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			bit_cnt_q <= 3'h0;
			in_sr_q   <= 8'h00;
		end else if (cs_n_s) begin
			bit_cnt_q <= 3'h0;
		end else if (sclk_rise) begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			in_sr_q   <= in_next;
		end
	end

	// Opcode and register selection held for the rest of the frame
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			op_q   <= 8'h00;
			sel3_q <= 1'b0;
		end else if (op_end) begin
			op_q   <= in_next;
			sel3_q <= is_read3(in_next);
		end
	end

	// Serial output: a fresh snapshot at every byte start, so polling sees changes
	always_comb begin
		out_sr_d = out_sr_q;
		miso_d   = o_spi_miso;
		if ((state_q == S_READ) && sclk_fall) begin
			if (out_cnt_q == 3'h0) begin
				miso_d   = read_byte[7];
				out_sr_d = {read_byte[6:0], 1'b0};
			end else begin
				miso_d   = out_sr_q[7];
				out_sr_d = {out_sr_q[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			out_cnt_q     <= 3'h0;
			out_sr_q      <= 8'h00;
			o_spi_miso    <= 1'b0;
			o_spi_miso_oe <= 1'b0;
		end else begin
			out_cnt_q     <= cs_n_s ? 3'h0 : ((state_q == S_READ) && sclk_fall) ?
				out_cnt_q + 3'h1 : out_cnt_q;
			out_sr_q      <= out_sr_d;
			o_spi_miso    <= miso_d;
			o_spi_miso_oe <= (state_d == S_READ);
		end
	end

	// Write latch: set by a bare enable frame, dropped by disable or a landed write
	always_comb begin
		wel_d = wel_q;
		if (op_only && (op_q == OP_WREN)) begin
			wel_d = 1'b1;
		end else if ((op_only && (op_q == OP_WRDI)) || wr_commit) begin
			wel_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			wel_q <= 1'b0;
		end else begin
			wel_q <= wel_d;
		end
	end

	// Register two: suspend flags set by events, set beats a clearing resume
	always_comb begin
		sr2_d = sr2_q;
		sr2_d.erase_suspended_flag   = i_erase_suspend |
			(sr2_q.erase_suspended_flag & ~i_erase_resume);
		sr2_d.program_suspended_flag = i_program_suspend |
			(sr2_q.program_suspended_flag & ~i_program_resume);
		sr2_d.write_busy_flag        = 1'b0;
		if (wr_sr2) begin
			sr2_d.protection_complement = in_sr_q[6];
			sr2_d.quad_pin_takeover     = in_sr_q[1];
			// One-time locks: a written 1 sticks, a written 0 changes nothing
			sr2_d.security_lock_a = sr2_q.security_lock_a | in_sr_q[5];
			sr2_d.security_lock_b = sr2_q.security_lock_b | in_sr_q[4];
			sr2_d.security_lock_c = sr2_q.security_lock_c | in_sr_q[3];
		end
	end

	// Register three: blank flag only ever falls; mode flag follows mode commands
	always_comb begin
		sr3_d = sr3_q;
		if (i_byte_programmed) begin
			sr3_d.blank_check = 1'b0;
		end
		if (!mode_init_q) begin
			sr3_d.current_address_mode_flag = sr3_q.poweron_address_mode;
		end else if (i_enter_current_address_mode_flag) begin
			sr3_d.current_address_mode_flag = 1'b1;
		end else if (i_exit_current_address_mode_flag) begin
			sr3_d.current_address_mode_flag = 1'b0;
		end
		if (wr_sr3) begin
			sr3_d.shared_pin_function_select = in_sr_q[7];
			sr3_d.drive_strength             = in_sr_q[6:5];
			sr3_d.wrap_length                = in_sr_q[4:3];
			sr3_d.poweron_address_mode       = in_sr_q[1];
		end
	end

	// Reset brings volatile flags to zero and configuration to factory values
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			sr2_q       <= SR2_RESET;
			sr3_q       <= SR3_RESET;
			mode_init_q <= 1'b0;
		end else begin
			sr2_q       <= sr2_d;
			sr3_q       <= sr3_d;
			mode_init_q <= 1'b1;
		end
	end

	// Pin functions are honoured only while quad takeover is off
	wire pins_owned = ~sr2_q.quad_pin_takeover;
	wire hold_sel   = pins_owned & ~sr3_q.shared_pin_function_select;
	wire rst_sel    = pins_owned & sr3_q.shared_pin_function_select;

	// Quad opcodes are recognised whatever the takeover bit holds
	wire quad_rd = op_end && (in_next == OP_QUAD_READ);
	wire quad_pe = op_end && (in_next == OP_QUAD_PERI);

	// All outputs registered; decoded views lag their source by one cycle
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_second_status         <= 8'h00;
			o_third_status          <= 8'h00;
			o_security_lock         <= 3'h0;
			o_protection_complement <= 1'b0;
			o_write_protect_active  <= 1'b0;
			o_hold_active           <= 1'b0;
			o_pin_reset_active      <= 1'b0;
			o_drive_percent         <= 7'h00;
			o_wrap_bytes            <= 7'h00;
			o_address_current_address_mode_flag         <= 1'b0;
			o_quad_read_start       <= 1'b0;
			o_quad_mode_entry       <= 1'b0;
		end else begin
			o_second_status         <= sr2_view;
			o_third_status          <= sr3_view;
			o_security_lock         <= {sr2_q.security_lock_a, sr2_q.security_lock_b,
				sr2_q.security_lock_c};
			o_protection_complement <= sr2_q.protection_complement;
			o_write_protect_active  <= pins_owned & ~wp_n_s;
			o_hold_active           <= hold_sel & ~hold_n_s;
			o_pin_reset_active      <= rst_sel & ~hold_n_s;
			o_drive_percent         <= drive_pct(sr3_q.drive_strength);
			o_wrap_bytes            <= WRAP_BASE_BYTES << sr3_q.wrap_length;
			o_address_current_address_mode_flag         <= sr3_q.current_address_mode_flag;
			o_quad_read_start       <= quad_rd;
			o_quad_mode_entry       <= quad_pe;
		end
	end

endmodule

//--- design/fsr_pkg.sv
package fsr_pkg;

	// Serial opcodes understood by this block
	localparam logic [7:0] OP_READ2_A   = 8'h09;
	localparam logic [7:0] OP_READ2_B   = 8'h35;
	localparam logic [7:0] OP_READ3_A   = 8'h95;
	localparam logic [7:0] OP_READ3_B   = 8'h15;
	localparam logic [7:0] OP_WRITE2    = 8'h31;
	localparam logic [7:0] OP_WRITE3_A  = 8'hc0;
	localparam logic [7:0] OP_WRITE3_B  = 8'h11;
	localparam logic [7:0] OP_WREN      = 8'h06;
	localparam logic [7:0] OP_WRDI      = 8'h04;
	localparam logic [7:0] OP_QUAD_READ = 8'heb;
	localparam logic [7:0] OP_QUAD_PERI = 8'h38;

	// Register 2 layout, most significant field first, so a cast gives the byte
	typedef struct packed {
		logic erase_suspended_flag;   // bit 7
		logic protection_complement;  // bit 6
		logic security_lock_a;        // bit 5
		logic security_lock_b;        // bit 4
		logic security_lock_c;        // bit 3
		logic program_suspended_flag; // bit 2
		logic quad_pin_takeover;      // bit 1
		logic write_busy_flag;        // bit 0
	} fsr_sr2_t;

	// Register 3 layout
	typedef struct packed {
		logic       shared_pin_function_select; // bit 7
		logic [1:0] drive_strength;             // bits 6:5
		logic [1:0] wrap_length;                // bits 4:3
		logic       blank_check;                // bit 2
		logic       poweron_address_mode;       // bit 1
		logic       current_address_mode_flag;  // bit 0
	} fsr_sr3_t;

	// Factory defaults; the array ships blank
	localparam fsr_sr2_t SR2_RESET = 8'h00;
	localparam fsr_sr3_t SR3_RESET = 8'h04;

	// Drive strength codes in percent
	localparam logic [6:0] DRIVE_PCT_00 = 7'h43;
	localparam logic [6:0] DRIVE_PCT_01 = 7'h64;
	localparam logic [6:0] DRIVE_PCT_10 = 7'h53;
	localparam logic [6:0] DRIVE_PCT_11 = 7'h32;

	// Shortest wrap burst in bytes; each code step doubles it
	localparam logic [6:0] WRAP_BASE_BYTES = 7'h08;

	// Idle levels of the synchronised pins: sclk, cs_n, mosi, wp_n, hold_n
	// The link clock parks low, as the edge detector assumes, so reset makes no false edge
	localparam logic [4:0] PIN_IDLE = 5'h0b;

	// Serial frame states
	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_OPCODE = 3'b001,
		S_READ   = 3'b010,
		S_WDATA  = 3'b011,
		S_WDONE  = 3'b100,
		S_OPDONE = 3'b101,
		S_IGNORE = 3'b110
	} fsr_state_t;

endpackage

//--- design/fsr_sync.sv
`timescale 1ns/10ps
module fsr_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         i_clk,   // System clock
	input  wire logic         i_reset, // Asynchronous reset, active high
	input  wire logic [W-1:0] i_async, // Levels from outside the clock domain
	output logic      [W-1:0] o_sync   // Levels after two flops
);

	logic [W-1:0] meta_q;

	// Two flops per bit; the first is read only by the second
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_clk or posedge i_reset) begin
				if (i_reset) begin
					meta_q[g] <= INIT[g];
					o_sync[g] <= INIT[g];
				end else begin
					meta_q[g] <= i_async[g];
					o_sync[g] <= meta_q[g];
				end
			end
		end
	endgenerate

endmodule

//--- sim/fsr_status_regs_sva.sv
`timescale 1ns/10ps
// Port-level timing and mapping checks for the status register block
module fsr_status_regs_sva
	import fsr_pkg::*;
(
	input  wire logic       i_clk,                  // System clock
	input  wire logic       i_reset,                // Asynchronous reset
	input  wire logic       i_spi_cs_n,             // Chip select pin
	input  wire logic       i_erase_suspend,        // Erase suspend pulse
	input  wire logic       i_erase_resume,         // Erase resume pulse
	input  wire logic       i_program_suspend,      // Program suspend pulse
	input  wire logic       i_byte_programmed,      // Programming pulse
	input  wire logic       i_enter_current_address_mode_flag,          // Enter 4-byte pulse
	input  wire logic       o_spi_miso_oe,          // Data out enable
	input  wire logic [7:0] o_second_status,        // Register two view
	input  wire logic [7:0] o_third_status,         // Register three view
	input  wire logic [2:0] o_security_lock,        // Sector locks
	input  wire logic       o_write_protect_active, // Protect pin honoured
	input  wire logic       o_hold_active,          // Hold honoured
	input  wire logic       o_pin_reset_active,     // Pin reset honoured
	input  wire logic [6:0] o_drive_percent,        // Drive in percent
	input  wire logic [6:0] o_wrap_bytes,           // Wrap length
	input  wire logic       o_address_current_address_mode_flag,        // Address mode
	input  wire logic       o_quad_read_start       // Quad read pulse
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	// Flags follow their pulses two cycles later; set wins a tie
	esusp_set_a: assert property (i_erase_suspend |-> ##2 o_second_status[7])
		else $error("erase suspend flag missing");
	esusp_clr_a: assert property (
		(i_erase_resume && !i_erase_suspend) ##1 !i_erase_suspend |=> !o_second_status[7])
		else $error("erase suspend flag not cleared");
	psusp_set_a: assert property (i_program_suspend |-> ##2 o_second_status[2])
		else $error("program suspend flag missing");
	blank_clear_a: assert property (i_byte_programmed |-> ##[1:2] !o_third_status[2])
		else $error("blank flag not cleared");
	// Drive percent is nonzero only out of reset, so it marks a live view
	blank_sticky_a: assert property (
		o_drive_percent != 7'h00 && !o_third_status[2] |=> !o_third_status[2])
		else $error("blank flag came back");
	lock_sticky_a: assert property (o_security_lock != 3'h0 |=>
		(o_security_lock & $past(o_security_lock)) == $past(o_security_lock))
		else $error("lock bit cleared");
	mode_enter_a: assert property (i_enter_current_address_mode_flag |-> ##[1:2] o_address_current_address_mode_flag)
		else $error("address mode flag not set");
	drive_map_a: assert property (($stable(o_third_status[6:5]))[*2] |->
		o_drive_percent == (o_third_status[6] ? (o_third_status[5] ? 7'h32 : 7'h53) :
		(o_third_status[5] ? 7'h64 : 7'h43)))
		else $error("drive percent mismatch");
	wrap_map_a: assert property (($stable(o_third_status[4:3]))[*2] |->
		o_wrap_bytes == (7'h08 << o_third_status[4:3]))
		else $error("wrap length mismatch");
	wp_qe_a: assert property (o_write_protect_active |-> !o_second_status[1])
		else $error("protect pin honoured with quad takeover");
	pin_excl_a: assert property (o_pin_reset_active |->
		o_third_status[7] && !o_hold_active && !o_second_status[1])
		else $error("pin reset function wrongly active");
	oe_idle_a: assert property (i_spi_cs_n [*5] |-> !o_spi_miso_oe)
		else $error("data out enabled while deselected");
	quad_pulse_a: assert property (o_quad_read_start |=> !o_quad_read_start)
		else $error("quad read pulse too long");
endmodule

bind fsr_status_regs fsr_status_regs_sva i_sva (.*);

//--- sim/fsr_host_model.sv
`timescale 1ns/10ps
// Host serial controller, mode 0; the link clock is parked low between frames
module fsr_host_model (
	input  wire logic i_clk,  // Bench clock, pacing only
	input  wire logic i_miso, // Data from the device
	output logic      o_sclk, // Link clock, 80 ns period at half = 5
	output logic      o_cs_n, // Chip select, active low
	output logic      o_mosi  // Data to the device
);
	int half = 5; // Half link period in bench cycles; raise it for a slow host

	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b1;
	end

	// One frame: opcode, then nbits out and in, MSB first, edges off the clock
	task automatic frame(input logic [7:0] op, input logic [15:0] wd, input int nbits,
		output logic [15:0] rd);
		logic [23:0] sh;
		sh = {op, wd};
		rd = 16'h0000;
		@(negedge i_clk);
		o_cs_n = 1'b0;
		for (int i = 0; i < 8 + nbits; i++) begin
			o_mosi = sh[23 - i];
			repeat (half) @(negedge i_clk);
			rd = {rd[14:0], i_miso}; // Device data is taken at the rise
			o_sclk = 1'b1;
			repeat (half) @(negedge i_clk);
			o_sclk = 1'b0;
		end
		repeat (half) @(negedge i_clk);
		o_cs_n = 1'b1;
		o_mosi = ~o_mosi; // Released line must not keep its last value
		repeat (half) @(negedge i_clk);
	endtask
endmodule

//--- sim/fsr_status_regs_tb.sv
`timescale 1ns/10ps
// Bench: the host model drives the link; each task judges its own scenario
module fsr_status_regs_tb;
	import fsr_pkg::*;

	localparam logic [7:0] PCT [4] = '{8'h43, 8'h64, 8'h53, 8'h32}; // Drive per code

	logic       clk, reset, sclk, cs_n, mosi, miso, moe, wp_n, hold_n, busy;
	logic       es, er, ps, pr, bp, e4, x4, wpa, hla, rsa, a4, qr, qm, cmp;
	logic [2:0] lock;
	logic [6:0] drv, wrp;
	int         n_mismatch, compares, n_qr, n_qm;
	wire        mline = moe ? miso : ~miso; // Released line shows the inverse of its last level

	fsr_status_regs i_dut (.i_clk(clk), .i_reset(reset), .i_spi_sclk(sclk),
		.i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .i_wp_n(wp_n), .i_hold_reset_n(hold_n),
		.i_write_busy(busy), .i_erase_suspend(es), .i_erase_resume(er),
		.i_program_suspend(ps), .i_program_resume(pr), .i_byte_programmed(bp),
		.i_enter_current_address_mode_flag(e4), .i_exit_current_address_mode_flag(x4), .o_spi_miso(miso), .o_spi_miso_oe(moe),
		.o_second_status(), .o_third_status(), .o_security_lock(lock),
		.o_protection_complement(cmp), .o_write_protect_active(wpa),
		.o_hold_active(hla), .o_pin_reset_active(rsa), .o_drive_percent(drv),
		.o_wrap_bytes(wrp), .o_address_current_address_mode_flag(a4), .o_quad_read_start(qr),
		.o_quad_mode_entry(qm));

	fsr_host_model i_host (.i_clk(clk), .i_miso(mline), .o_sclk(sclk), .o_cs_n(cs_n),
		.o_mosi(mosi));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Quad pulses last one cycle, so count them as they pass
	always @(posedge clk) begin
		if (qr === 1'b1) n_qr++;
		if (qm === 1'b1) n_qm++;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask

	// Reads two bytes in one frame: the register must repeat
	task automatic rdchk(input logic [7:0] op, input logic [7:0] exp);
		logic [15:0] r;
		i_host.frame(op, 16'h0000, 16, r);
		chk(r[15:8], exp, "first byte");
		chk(r[7:0], exp, "repeated byte");
	endtask

	task automatic wr(input logic [7:0] op, input logic [7:0] d);
		logic [15:0] r;
		i_host.frame(OP_WREN, 16'h0000, 0, r);
		i_host.frame(op, {d, 8'h00}, 8, r);
	endtask

	task automatic do_reset;
		reset = 1'b1;
		repeat (4) @(negedge clk);
		reset = 1'b0;
		repeat (4) @(negedge clk);
	endtask

	task automatic t_reset_view;
		rdchk(OP_READ2_A, 8'h00);
		rdchk(OP_READ2_B, 8'h00);
		rdchk(OP_READ3_A, 8'h04);
		rdchk(OP_READ3_B, 8'h04);
		chk(8'(drv), 8'h43, "drive default");
		chk(8'(wrp), 8'h08, "wrap default");
	endtask

	// Busy shows in bit 0 and blocks writes; short or unlatched writes die
	task automatic t_busy;
		logic [15:0] r;
		busy = 1'b1;
		rdchk(OP_READ2_B, 8'h01);
		i_host.frame(OP_READ2_A, 16'h0000, 8, r);
		chk(r[7:0] & 8'hfe, 8'h00, "masked view");
		wr(OP_WRITE2, 8'h02);
		rdchk(OP_READ2_A, 8'h01);
		busy = 1'b0;
		rdchk(OP_READ2_A, 8'h00);
		i_host.frame(OP_WRDI, 16'h0000, 0, r);
		i_host.frame(OP_WRITE2, 16'h0200, 8, r);
		i_host.frame(OP_WREN, 16'h0000, 0, r);
		i_host.frame(OP_WRITE2, 16'h0200, 7, r);
		i_host.frame(OP_WRDI, 16'h0000, 0, r);
		rdchk(OP_READ2_A, 8'h00);
	endtask

	task automatic t_suspend;
		pulse(es);
		pulse(ps);
		rdchk(OP_READ2_A, 8'h84);
		pulse(er);
		pulse(pr);
		rdchk(OP_READ2_B, 8'h00);
		@(negedge clk);
		{es, er} = 2'h3; // Suspend and resume together: the set wins
		@(negedge clk);
		{es, er} = 2'h0;
		rdchk(OP_READ2_A, 8'h80);
		pulse(er);
		rdchk(OP_READ2_B, 8'h00);
	endtask

	// Locks only accumulate; quad takeover silences the protect and hold pins
	task automatic t_write2;
		logic [15:0] r;
		int          q;
		wp_n = 1'b0;
		hold_n = 1'b0;
		repeat (4) @(negedge clk);
		chk(8'({wpa, hla, rsa}), 8'h06, "pins honoured");
		wr(OP_WRITE2, 8'h28);
		rdchk(OP_READ2_A, 8'h28);
		chk(8'(lock), 8'h05, "locks a c");
		wr(OP_WRITE2, 8'h52);
		rdchk(OP_READ2_A, 8'h7a);
		chk(8'({wpa, hla, cmp}), 8'h01, "takeover");
		q = n_qr;
		i_host.frame(OP_QUAD_READ, 16'h0000, 0, r);
		chk(8'(n_qr - q), 8'h01, "quad read with takeover");
		wr(OP_WRITE2, 8'h00);
		rdchk(OP_READ2_B, 8'h38);
		chk(8'({lock, cmp}), 8'h0e, "locks kept");
		q = n_qm;
		i_host.frame(OP_QUAD_PERI, 16'h0000, 0, r);
		chk(8'(n_qm - q), 8'h01, "quad entry no takeover");
	endtask

	task automatic t_write3;
		logic [1:0] k;
		wr(OP_WRITE3_A, 8'hff);
		rdchk(OP_READ3_A, 8'hfe);
		chk(8'({wpa, hla, rsa}), 8'h05, "pin is reset");
		for (int i = 0; i < 4; i++) begin
			k = 2'(i);
			wr(OP_WRITE3_B, {1'b0, k, k, 3'h0});
			rdchk(OP_READ3_B, {1'b0, k, k, 3'h4});
			chk(8'(drv), PCT[i], "drive");
			chk(8'(wrp), 8'h08 << i, "wrap");
		end
	endtask

	task automatic t_events;
		pulse(e4);
		repeat (3) @(negedge clk);
		chk(8'(a4), 8'h01, "4-byte mode");
		rdchk(OP_READ3_A, 8'h7d);
		pulse(x4);
		pulse(bp);
		rdchk(OP_READ3_A, 8'h78);
		do_reset();
		rdchk(OP_READ3_B, 8'h04);
		chk(8'(a4), 8'h00, "3-byte start");
	endtask

	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Whole run is near 73 us; the limit leaves ample margin
	initial begin
		#500us;
		n_mismatch++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		test_done();
	end

	initial begin
		{wp_n, hold_n, busy, es, er, ps, pr, bp, e4, x4} = 10'h300;
		do_reset();
		t_reset_view();
		t_busy();
		t_suspend();
		t_write2();
		t_write3();
		t_events();
		test_done();
	end
endmodule
